// ### rtl/mil_pkg.sv
// Constants and types for the misc interface lock and status-change register bank
//
// Contract
// - Lock bit at 1 discards every write to the three transceiver pin-config registers.
// - Function bit 1 and wakeup 1: writing 1 sets data bit, 0 does nothing.
// - Function bit 1: data bit clears whenever the card wakeup bit is 0.
// - Function bit 0: pin is driven with the inverse of the last written data.
// - Reading the data bit returns the inverse of the present pin level.
// - Status-change function works only when strapped for the PC Card bus.
// - Software writes zeros to six reserved registers; reads may return anything.
package mil_pkg;

  // ****************************************************************
  // Register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam int          ADDR_W      = 6;
  localparam int          DATA_W      = 32;
  localparam int          REG_W       = 8;
  localparam logic [5:0]  OFF_MIC9    = 6'h00;
  localparam logic [5:0]  OFF_RSV10   = 6'h04;
  localparam logic [5:0]  OFF_RSV11   = 6'h08;
  localparam logic [5:0]  OFF_RSV12   = 6'h0c;
  localparam logic [5:0]  OFF_RSV13   = 6'h10;
  localparam logic [5:0]  OFF_RSV14   = 6'h14;
  localparam logic [5:0]  OFF_RSV15   = 6'h18;
  localparam logic [5:0]  OFF_XCFG_A  = 6'h1c;
  localparam logic [5:0]  OFF_XCFG_B  = 6'h20;
  localparam logic [5:0]  OFF_XCFG_C  = 6'h24;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int          BIT_SC_DATA = 0;
  localparam int          BIT_LOCK    = 1;
  localparam int          BIT_SC_FN   = 0;
  localparam int          BE_LOW      = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic        RST_LOCK    = 1'b0;
  localparam logic        RST_SC_DATA = 1'b0;
  localparam logic [7:0]  RST_XCFG    = 8'h00;

  // Transceiver pin-function configuration carried as one group
  typedef struct packed {
    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic [7:0] cfg_c;
  } mil_xcfg_s;

  // Decoded register target of a bus access
  typedef enum logic [2:0] {
    MIL_SEL_NONE,
    MIL_SEL_MIC9,
    MIL_SEL_RSV,
    MIL_SEL_XA,
    MIL_SEL_XB,
    MIL_SEL_XC
  } mil_sel_e;

  // Bus handshake states
  typedef enum logic {
    MIL_IDLE,
    MIL_ACK
  } mil_bus_e;

endpackage

// ### rtl/mil_top.sv
// Misc interface control 9 register bank with transceiver config write lock
//
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
module mil_top
#(
  parameter logic [7:0] XCFG_RESET = mil_pkg::RST_XCFG
)
(
  input  wire logic                          ref_clk_i,
  input  wire logic                          rstn_i,
  input  wire logic [mil_pkg::ADDR_W-1:0]    avs_address_i,
  input  wire logic                          avs_read_i,
  input  wire logic                          avs_write_i,
  input  wire logic [mil_pkg::DATA_W-1:0]    avs_writedata_i,
  input  wire logic [3:0]                    avs_byteenable_i,
  output logic      [mil_pkg::DATA_W-1:0]    avs_readdata_o,
  output logic                               avs_waitrequest_o,
  input  wire logic                          card_wakeup_i,
  input  wire logic                          pccard_strap_i,
  input  wire logic                          status_change_pin_i,
  output logic                               status_change_pin_o,
  output logic                               status_change_pin_oe_n_o,
  output mil_pkg::mil_xcfg_s                 xcvr_cfg_o,
  output logic                               config_write_lock_o
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic mil_pkg::mil_sel_e decode(input logic [mil_pkg::ADDR_W-1:0] addr);
    mil_pkg::mil_sel_e sel;
    sel = mil_pkg::MIL_SEL_NONE;
    case (addr)
      mil_pkg::OFF_MIC9:   sel = mil_pkg::MIL_SEL_MIC9;
      mil_pkg::OFF_RSV10,
      mil_pkg::OFF_RSV11,
      mil_pkg::OFF_RSV12,
      mil_pkg::OFF_RSV13,
      mil_pkg::OFF_RSV14,
      mil_pkg::OFF_RSV15:  sel = mil_pkg::MIL_SEL_RSV;
      mil_pkg::OFF_XCFG_A: sel = mil_pkg::MIL_SEL_XA;
      mil_pkg::OFF_XCFG_B: sel = mil_pkg::MIL_SEL_XB;
      mil_pkg::OFF_XCFG_C: sel = mil_pkg::MIL_SEL_XC;
      default:             sel = mil_pkg::MIL_SEL_NONE;
    endcase
    return sel;
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic strap_s1_q;
  logic strap_s2_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic strap_s1_d;
  logic strap_s2_d;
  logic pin_s1_d;
  logic pin_s2_d;
  // Only the second stage of each pair feeds any logic

  always_comb
  begin
    strap_s1_d = pccard_strap_i;
    strap_s2_d = strap_s1_q;
    pin_s1_d   = status_change_pin_i;
    pin_s2_d   = pin_s1_q;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
      pin_s1_q   <= 1'b0;
      pin_s2_q   <= 1'b0;
    end
    else
    begin
      strap_s1_q <= strap_s1_d;
      strap_s2_q <= strap_s2_d;
      pin_s1_q   <= pin_s1_d;
      pin_s2_q   <= pin_s2_d;
    end
  end

  // ****************************************************************
  // Avalon slave handshake: one wait cycle per access
  // ****************************************************************
  mil_pkg::mil_bus_e            bus_q;
  mil_pkg::mil_bus_e            bus_d;
  logic [mil_pkg::DATA_W-1:0]   rdata_q;
  logic [mil_pkg::DATA_W-1:0]   rdata_d;
  mil_pkg::mil_sel_e            sel;
  logic                         wr_take;
  logic                         low_lane;

  assign sel               = decode(avs_address_i);
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && (bus_q != mil_pkg::MIL_ACK);
  assign low_lane          = avs_byteenable_i[mil_pkg::BE_LOW];
  assign wr_take           = avs_write_i && (bus_q == mil_pkg::MIL_ACK) && low_lane;
  assign avs_readdata_o    = rdata_q;

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic               lock_q;
  logic               lock_d;
  logic               sc_data_q;
  logic               sc_data_d;
  logic               pin_q;
  logic               pin_d;
  logic               oe_n_q;
  logic               oe_n_d;
  mil_pkg::mil_xcfg_s xcfg_q;
  mil_pkg::mil_xcfg_s xcfg_d;
  logic               sc_fn;
  logic               pccard;
  logic [7:0]         wbyte;

  assign sc_fn  = xcfg_q.cfg_c[mil_pkg::BIT_SC_FN];
  assign pccard = strap_s2_q;
  assign wbyte  = avs_writedata_i[mil_pkg::REG_W-1:0];

  always_comb
  begin
    bus_d     = bus_q;
    rdata_d   = rdata_q;
    lock_d    = lock_q;
    sc_data_d = sc_data_q;
    xcfg_d    = xcfg_q;
    case (bus_q)
      mil_pkg::MIL_IDLE:
      begin
        if (avs_read_i || avs_write_i)
        begin
          bus_d   = mil_pkg::MIL_ACK;
          rdata_d = '0;
          // Reserved and unmapped words read as zero
          if (avs_read_i)
          begin
            case (sel)
              mil_pkg::MIL_SEL_MIC9:
              begin
                rdata_d[mil_pkg::BIT_LOCK]    = lock_q;
                rdata_d[mil_pkg::BIT_SC_DATA] = ~pin_s2_q;
              end
              mil_pkg::MIL_SEL_XA: rdata_d[mil_pkg::REG_W-1:0] = xcfg_q.cfg_a;
              mil_pkg::MIL_SEL_XB: rdata_d[mil_pkg::REG_W-1:0] = xcfg_q.cfg_b;
              mil_pkg::MIL_SEL_XC: rdata_d[mil_pkg::REG_W-1:0] = xcfg_q.cfg_c;
              default:             rdata_d = '0;
            endcase
          end
        end
      end
      mil_pkg::MIL_ACK:
      begin
        bus_d = mil_pkg::MIL_IDLE;
        if (wr_take)
        begin
          case (sel)
            mil_pkg::MIL_SEL_MIC9:
            begin
              lock_d = wbyte[mil_pkg::BIT_LOCK];
              if (!sc_fn)
                sc_data_d = wbyte[mil_pkg::BIT_SC_DATA];
              else if (card_wakeup_i && wbyte[mil_pkg::BIT_SC_DATA])
                sc_data_d = 1'b1;
            end
            mil_pkg::MIL_SEL_XA: if (!lock_q) xcfg_d.cfg_a = wbyte;
            mil_pkg::MIL_SEL_XB: if (!lock_q) xcfg_d.cfg_b = wbyte;
            mil_pkg::MIL_SEL_XC: if (!lock_q) xcfg_d.cfg_c = wbyte;
            // Reserved words keep nothing; software is expected to write zeros
            default:             xcfg_d = xcfg_q;
          endcase
        end
      end
      default: bus_d = mil_pkg::MIL_IDLE;
    endcase
    // Wakeup latch mode: wakeup low always clears, no set can race it
    if (sc_fn && !card_wakeup_i)
      sc_data_d = 1'b0;
  end

  // Pin path: inverse of data in both modes; wakeup mode just changes how data moves
  always_comb
  begin
    pin_d  = ~sc_data_d;
    oe_n_d = ~pccard;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      bus_q     <= mil_pkg::MIL_IDLE;
      rdata_q   <= '0;
      lock_q    <= mil_pkg::RST_LOCK;
      sc_data_q <= mil_pkg::RST_SC_DATA;
      pin_q     <= 1'b1;
      oe_n_q    <= 1'b1;
      xcfg_q    <= {XCFG_RESET, XCFG_RESET, XCFG_RESET};
    end
    else
    begin
      bus_q     <= bus_d;
      rdata_q   <= rdata_d;
      lock_q    <= lock_d;
      sc_data_q <= sc_data_d;
      pin_q     <= pin_d;
      oe_n_q    <= oe_n_d;
      xcfg_q    <= xcfg_d;
    end
  end

  // Outside PC Card mode the pin belongs to the latch-enable function, so stay off it
  assign status_change_pin_o      = pin_q;
  assign status_change_pin_oe_n_o = oe_n_q;
  assign xcvr_cfg_o               = xcfg_q;
  assign config_write_lock_o      = lock_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic xw_any;
  assign xw_any = wr_take && (sel == mil_pkg::MIL_SEL_XA || sel == mil_pkg::MIL_SEL_XB
                              || sel == mil_pkg::MIL_SEL_XC);

  lock_blocks_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (xw_any && lock_q) |=> (xcfg_q == $past(xcfg_q)))
    else $error("transceiver config changed while locked");

  unlock_write_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (wr_take && sel == mil_pkg::MIL_SEL_XA && !lock_q) |=> (xcfg_q.cfg_a == $past(wbyte)))
    else $error("unlocked config write not stored");

  wake_set_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (wr_take && sel == mil_pkg::MIL_SEL_MIC9 && sc_fn && card_wakeup_i
     && wbyte[mil_pkg::BIT_SC_DATA]) |=> sc_data_q)
    else $error("status change data not set in wakeup mode");

  wake_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (sc_fn && card_wakeup_i && !(wr_take && sel == mil_pkg::MIL_SEL_MIC9)) |=>
    (sc_data_q == $past(sc_data_q) || !$past(card_wakeup_i)))
    else $error("status change data moved without a write");

  wake_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (sc_fn && !card_wakeup_i) |=> (!sc_data_q && pin_q))
    else $error("status change data not cleared on wakeup low");

  direct_drive_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (wr_take && sel == mil_pkg::MIL_SEL_MIC9 && !sc_fn && !(sc_fn && !card_wakeup_i))
    |=> ##1 (pin_q == !$past(wbyte[mil_pkg::BIT_SC_DATA], 2)))
    else $error("pin not inverse of written data");

  readback_inv_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (avs_read_i && bus_q == mil_pkg::MIL_IDLE && sel == mil_pkg::MIL_SEL_MIC9)
    |=> (avs_readdata_o[mil_pkg::BIT_SC_DATA] == !$past(pin_s2_q)) && !avs_waitrequest_o)
    else $error("data bit readback not inverse of pin");

  mode_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !strap_s2_q |=> status_change_pin_oe_n_o)
    else $error("pin driven outside PC Card mode");

  rsvd_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (avs_read_i && bus_q == mil_pkg::MIL_IDLE && sel == mil_pkg::MIL_SEL_RSV)
    |=> (avs_readdata_o == '0))
    else $error("reserved register read not zero");

  // Reserved words hold no state, so a write there must disturb nothing
  rsvd_ignore_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (wr_take && sel == mil_pkg::MIL_SEL_RSV)
    |=> (xcfg_q == $past(xcfg_q) && lock_q == $past(lock_q)))
    else $error("reserved register write changed state");

  // Lock bit stays writable, else a set lock could never be undone
  lock_free_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (wr_take && sel == mil_pkg::MIL_SEL_MIC9)
    |=> (lock_q == $past(wbyte[mil_pkg::BIT_LOCK])))
    else $error("lock bit write not stored");

  mode_drive_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    strap_s2_q |=> !status_change_pin_oe_n_o)
    else $error("pin not driven in PC Card mode");

  wake_noset_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (wr_take && sel == mil_pkg::MIL_SEL_MIC9 && sc_fn && !card_wakeup_i)
    |=> !sc_data_q)
    else $error("status change data set with wakeup low");

  unlock_cfgb_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (wr_take && sel == mil_pkg::MIL_SEL_XB && !lock_q) |=> (xcfg_q.cfg_b == $past(wbyte)))
    else $error("unlocked config b write not stored");

  unlock_cfgc_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (wr_take && sel == mil_pkg::MIL_SEL_XC && !lock_q) |=> (xcfg_q.cfg_c == $past(wbyte)))
    else $error("unlocked config c write not stored");

  reset_clear_a: assert property (@(posedge ref_clk_i)
    $rose(rstn_i) |-> (!lock_q && !sc_data_q))
    else $error("lock or data bit not clear after reset");

endmodule

// ### verification/mil_pin_model.sv
// Model of the status change line as the card socket sees it
`timescale 1ns/10ps
module mil_pin_model
(
  input  wire logic pin_drv_i,
  input  wire logic pin_oe_n_i,
  input  wire logic ext_lvl_i,
  output logic      pin_lvl_o
);
  // Released line follows the host level, which idles high as a pull-up would
  assign pin_lvl_o = pin_oe_n_i ? ext_lvl_i : pin_drv_i;
endmodule

// ### verification/testbench.sv
// Self-checking bench for the misc interface lock and status-change bank
`timescale 1ns/10ps
module testbench;
  logic               clk;
  logic               rstn;
  logic [5:0]         av_addr;
  logic               av_rd;
  logic               av_wr;
  logic [31:0]        av_wd;
  logic [3:0]         av_be;
  logic [31:0]        av_rdata;
  logic               av_wait;
  logic               wake;
  logic               strap;
  logic               ext_lvl;
  logic               pin_lvl;
  logic               pin_o;
  logic               pin_oe_n;
  logic               lock;
  mil_pkg::mil_xcfg_s xcfg;
  logic [31:0]        rdv;
  int                 n_fail;
  int                 num_checks;
  int                 cyc;

  initial clk = 1'b0;
  always #2 clk = ~clk;

  mil_top i_mil_top (
    .ref_clk_i(clk), .rstn_i(rstn), .avs_address_i(av_addr), .avs_read_i(av_rd),
    .avs_write_i(av_wr), .avs_writedata_i(av_wd), .avs_byteenable_i(av_be),
    .avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait), .card_wakeup_i(wake),
    .pccard_strap_i(strap), .status_change_pin_i(pin_lvl), .status_change_pin_o(pin_o),
    .status_change_pin_oe_n_o(pin_oe_n), .xcvr_cfg_o(xcfg), .config_write_lock_o(lock));

  mil_pin_model i_mil_pin_model (
    .pin_drv_i(pin_o), .pin_oe_n_i(pin_oe_n), .ext_lvl_i(ext_lvl), .pin_lvl_o(pin_lvl));

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge clk);
    av_addr <= a;
    av_wd   <= d;
    av_be   <= be;
    av_wr   <= w;
    av_rd   <= ~w;
    @(posedge clk);
    // Waitrequest and read data are seen as they stood just before the edge
    while (av_wait !== 1'b0)
      @(posedge clk);
    rdv = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    acc(1'b1, a, {24'h000000, d}, 4'h1);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    acc(1'b0, a, 32'h00000000, 4'h1);
    chk(rdv, {24'h000000, e});
  endtask

  // Pin readback goes through a synchroniser, so let it land first
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail++;
      close_out();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    rstn = 1'b0; av_addr = 6'h00; av_rd = 1'b0; av_wr = 1'b0; av_wd = 32'h0;
    av_be = 4'h0; wake = 1'b0; strap = 1'b1; ext_lvl = 1'b1;
    n_fail = 0; num_checks = 0; cyc = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    chk({30'h0, lock, pin_o}, 32'h1);
    settle();
    chk({31'h0, pin_oe_n}, 32'h0);
    rd(mil_pkg::OFF_MIC9, 8'h00);
    wr(mil_pkg::OFF_XCFG_A, 8'h5a);
    wr(mil_pkg::OFF_XCFG_B, 8'ha5);
    wr(mil_pkg::OFF_XCFG_C, 8'h3c);
    acc(1'b1, mil_pkg::OFF_XCFG_B, 32'h000000ff, 4'h0);
    rd(mil_pkg::OFF_XCFG_B, 8'ha5);
    wr(mil_pkg::OFF_MIC9, 8'h02);
    rd(mil_pkg::OFF_MIC9, 8'h02);
    wr(mil_pkg::OFF_XCFG_A, 8'hff);
    wr(mil_pkg::OFF_XCFG_C, 8'h01);
    rd(mil_pkg::OFF_XCFG_A, 8'h5a);
    chk({8'h00, xcfg}, 32'h005aa53c);
    wr(mil_pkg::OFF_MIC9, 8'h00);
    wr(mil_pkg::OFF_XCFG_A, 8'h81);
    rd(mil_pkg::OFF_XCFG_A, 8'h81);
    // Direct mode: pin carries the inverse of the written bit
    for (int v = 1; v >= 0; v--)
    begin
      wr(mil_pkg::OFF_MIC9, 8'(v));
      settle();
      chk({31'h0, pin_o}, 32'(1 - v));
      rd(mil_pkg::OFF_MIC9, 8'(v));
    end
    // Wakeup mode: set only with wakeup high, cleared when it drops
    wr(mil_pkg::OFF_XCFG_C, 8'h01);
    wr(mil_pkg::OFF_MIC9, 8'h01);
    settle();
    chk({31'h0, pin_o}, 32'h1);
    wake <= 1'b1;
    wr(mil_pkg::OFF_MIC9, 8'h01);
    settle();
    chk({31'h0, pin_o}, 32'h0);
    wr(mil_pkg::OFF_MIC9, 8'h00);
    settle();
    rd(mil_pkg::OFF_MIC9, 8'h01);
    wake <= 1'b0;
    settle();
    chk({31'h0, pin_o}, 32'h1);
    // Other bus mode: pin released, readback is the inverse of the host level
    strap <= 1'b0;
    wake  <= 1'b1;
    wr(mil_pkg::OFF_MIC9, 8'h01);
    ext_lvl <= 1'b0;
    settle();
    chk({30'h0, pin_oe_n, pin_lvl}, 32'h2);
    rd(mil_pkg::OFF_MIC9, 8'h01);
    ext_lvl <= 1'b1;
    settle();
    rd(mil_pkg::OFF_MIC9, 8'h00);
    for (int i = 1; i < 7; i++)
    begin
      wr(6'(4 * i), 8'h00);
      acc(1'b0, 6'(4 * i), 32'h0, 4'h1);
    end
    rd(6'h3c, 8'h00);
    chk({8'h00, xcfg}, 32'h0081a501);
    // Mid-run reset with the lock set
    wr(mil_pkg::OFF_MIC9, 8'h02);
    rstn <= 1'b0;
    @(posedge clk);
    chk({7'h0, lock, xcfg}, 32'h0);
    rstn <= 1'b1;
    wr(mil_pkg::OFF_XCFG_B, 8'h33);
    rd(mil_pkg::OFF_XCFG_B, 8'h33);
    close_out();
  end
endmodule
